// [inc/vdc_pkg.sv]
// What this block does
// - Enable powers converter and drives pin
// - Clearing enable switches converter off
// - Disabled converter gives no valid output
// - Twelve-bit sample, top eight from high
// - Low four sample bits from low[7:4]
// - Low register bits 3..0 read zero
// - Eight volume levels in control[7:5]
// - Volume zero minimum, seven maximum
// - Control bits 4..1 read zero
// - Enable is control bit 0, read/write
// - Enable overrides the pin's other function
package vdc_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int SAMPLE_W = 12;
    localparam int VOL_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_LOW  = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_HIGH = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 2'h2;
    localparam int LOW_NIB_LSB = 4;
    localparam int VOL_LSB = 5;
    localparam int EN_BIT = 0;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
    localparam logic [3:0] NIB_ZERO = 4'h0;
    localparam logic [VOL_W-1:0] VOL_MIN = 3'h0;
    localparam logic [VOL_W-1:0] VOL_MAX = 3'h7;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } vdc_bus_t;

    typedef struct packed {
        logic                valid;
        logic [VOL_W-1:0]    volume;
        logic [SAMPLE_W-1:0] sample;
    } vdc_out_t;
endpackage

// [rtl/vdc_top.sv]
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module vdc_top (
    input  wire logic                   clk_sys,
    input  wire logic                   nrst,
    input  wire vdc_pkg::vdc_bus_t      bus,
    output logic [vdc_pkg::DATA_W-1:0]  rdata,
    input  wire logic                   pin_alt_out,
    input  wire logic                   pin_alt_oe_n,
    output vdc_pkg::vdc_out_t           conv,
    output logic                        pin_sel_conv,
    output logic                        pin_out,
    output logic                        pin_oe_n
);
    import vdc_pkg::*;

    logic [3:0]          low_q;
    logic [DATA_W-1:0]   high_q;
    logic [VOL_W-1:0]    vol_q;
    logic                en_q;
    logic [DATA_W-1:0]   rdata_q;
    vdc_out_t            conv_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Reserved control bits between volume and enable
    localparam logic [VOL_LSB-EN_BIT-2:0] RSV_ZERO = '0;

    // Register index match, shared by write and read decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] idx);
        return a == idx;
    endfunction

    wire wr_low  = bus.wr && hit(bus.addr, ADDR_LOW);
    wire wr_high = bus.wr && hit(bus.addr, ADDR_HIGH);
    wire wr_ctrl = bus.wr && hit(bus.addr, ADDR_CTRL);
    wire rd_low  = bus.rd && hit(bus.addr, ADDR_LOW);
    wire rd_high = bus.rd && hit(bus.addr, ADDR_HIGH);
    wire rd_ctrl = bus.rd && hit(bus.addr, ADDR_CTRL);

    wire [DATA_W-1:0] low_rd  = {low_q, NIB_ZERO};
    wire [DATA_W-1:0] ctrl_rd = {vol_q, RSV_ZERO, en_q};
    // Unmapped index reads as zero
    wire [DATA_W-1:0] rd_mux  =
        rd_low  ? low_rd  :
        rd_high ? high_q  :
        rd_ctrl ? ctrl_rd : REG_RESET;

    wire [SAMPLE_W-1:0] sample_w = {high_q, low_q};

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            low_q <= NIB_ZERO;
        end else if (wr_low) begin
            low_q <= bus.wdata[DATA_W-1:LOW_NIB_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            high_q <= REG_RESET;
        end else if (wr_high) begin
            high_q <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vol_q <= VOL_MIN;
        end else if (wr_ctrl) begin
            vol_q <= bus.wdata[DATA_W-1:VOL_LSB];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            en_q <= 1'b0;
        end else if (wr_ctrl) begin
            en_q <= bus.wdata[EN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            rdata_q <= REG_RESET;
        else if (bus.rd)
            rdata_q <= rd_mux;
        else
            rdata_q <= REG_RESET;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)
            conv_q <= '0;
        else begin
            conv_q.valid  <= en_q;
            conv_q.volume <= en_q ? vol_q : VOL_MIN;
            conv_q.sample <= en_q ? sample_w : '0;
        end
    end

    assign rdata = rdata_q;
    assign conv  = conv_q;
    assign pin_sel_conv = en_q;
    assign pin_out  = en_q ? 1'b0 : pin_alt_out;
    assign pin_oe_n = en_q ? 1'b1 : pin_alt_oe_n;

    // Register storage
    sample_hi_a: assert property (
        wr_high
        |=> high_q == $past(bus.wdata))
        else $error("high sample byte not stored");

    sample_lo_a: assert property (
        wr_low
        |=> low_q == $past(bus.wdata[DATA_W-1:LOW_NIB_LSB]))
        else $error("low sample nibble not stored");

    vol_field_a: assert property (
        wr_ctrl
        |=> vol_q == $past(bus.wdata[DATA_W-1:VOL_LSB]))
        else $error("volume field not stored");

    en_store_a: assert property (
        wr_ctrl
        |=> en_q == $past(bus.wdata[EN_BIT]))
        else $error("enable bit not stored");

    hi_hold_a: assert property (
        !wr_high
        |=> $stable(high_q))
        else $error("high sample byte changed without write");

    lo_hold_a: assert property (
        !wr_low
        |=> $stable(low_q))
        else $error("low sample nibble changed without write");

    ctrl_hold_a: assert property (
        !wr_ctrl
        |=> $stable(vol_q) && $stable(en_q))
        else $error("control changed without write");

    hi_side_a: assert property (
        wr_high
        |=> $stable(low_q) && $stable(vol_q) && $stable(en_q))
        else $error("high write disturbed another register");

    lo_side_a: assert property (
        wr_low
        |=> $stable(high_q) && $stable(vol_q) && $stable(en_q))
        else $error("low write disturbed another register");

    ctrl_side_a: assert property (
        wr_ctrl
        |=> $stable(high_q) && $stable(low_q))
        else $error("control write disturbed the sample");

    // Register readback, one cycle after the read strobe
    low_read_a: assert property (
        rd_low
        |=> rdata[LOW_NIB_LSB-1:0] == NIB_ZERO)
        else $error("low register reserved bits nonzero");

    low_nib_a: assert property (
        rd_low
        |=> rdata[DATA_W-1:LOW_NIB_LSB] == $past(low_q))
        else $error("low nibble readback wrong");

    high_read_a: assert property (
        rd_high
        |=> rdata == $past(high_q))
        else $error("high byte readback wrong");

    ctrl_read_a: assert property (
        rd_ctrl
        |=> rdata[VOL_LSB-1:EN_BIT+1] == RSV_ZERO)
        else $error("control reserved bits nonzero");

    vol_read_a: assert property (
        rd_ctrl
        |=> rdata[DATA_W-1:VOL_LSB] == $past(vol_q))
        else $error("volume readback wrong");

    en_bit_a: assert property (
        rd_ctrl
        |=> rdata[EN_BIT] == $past(en_q))
        else $error("enable bit not at position zero");

    // Converter feed, one cycle behind the registers
    en_set_a: assert property (
        wr_ctrl && bus.wdata[EN_BIT]
        |=> en_q ##1 conv.valid)
        else $error("enable did not start converter");

    en_clr_a: assert property (
        wr_ctrl && !bus.wdata[EN_BIT]
        |=> !en_q ##1 !conv.valid)
        else $error("disable did not stop converter");

    valid_follow_a: assert property (
        $past(en_q)
        |-> conv.valid)
        else $error("converter feed not valid while enabled");

    no_valid_a: assert property (
        !$past(en_q)
        |-> !conv.valid && conv.sample == '0)
        else $error("output valid while disabled");

    no_vol_a: assert property (
        !$past(en_q)
        |-> conv.volume == VOL_MIN)
        else $error("volume shown while disabled");

    feed_sample_a: assert property (
        $past(en_q)
        |-> conv.sample == {$past(high_q), $past(low_q)})
        else $error("sample not passed to converter");

    hi_top_a: assert property (
        $past(en_q)
        |-> conv.sample[SAMPLE_W-1:SAMPLE_W-DATA_W] == $past(high_q))
        else $error("sample top byte misplaced");

    lo_bottom_a: assert property (
        $past(en_q)
        |-> conv.sample[SAMPLE_W-DATA_W-1:0] == $past(low_q))
        else $error("sample bottom nibble misplaced");

    off_sample_a: assert property (
        $fell(en_q)
        |=> !conv.valid)
        else $error("converter feed outlived the enable");

    vol_out_a: assert property (
        en_q && $stable(en_q) && $stable(vol_q)
        |=> conv.volume == $past(vol_q))
        else $error("volume not passed to converter");

    vol_max_a: assert property (
        $past(en_q) && $past(vol_q) == VOL_MAX
        |-> conv.volume == VOL_MAX)
        else $error("maximum volume not passed on");

    vol_min_a: assert property (
        $past(en_q) && $past(vol_q) == VOL_MIN
        |-> conv.volume == VOL_MIN)
        else $error("minimum volume not passed on");

    // Shared pin routing
    pin_own_a: assert property (
        en_q
        |-> pin_sel_conv && pin_oe_n && !pin_out)
        else $error("alternate function not suppressed");

    pin_pass_a: assert property (
        !en_q
        |-> !pin_sel_conv && pin_out == pin_alt_out
        && pin_oe_n == pin_alt_oe_n)
        else $error("alternate function not passed through");

    pin_route_a: assert property (
        $rose(en_q)
        |-> pin_sel_conv)
        else $error("enable did not route pin");

    pin_free_a: assert property (
        $fell(en_q)
        |-> !pin_sel_conv)
        else $error("disable did not release pin");

    // State right after reset
    reset_a: assert property (
        $rose(nrst)
        |-> !en_q && vol_q == VOL_MIN && high_q == REG_RESET
        && low_q == NIB_ZERO)
        else $error("reset state wrong");

    reset_out_a: assert property (
        $rose(nrst)
        |-> !conv.valid && rdata == REG_RESET)
        else $error("outputs not cleared by reset");

    // Main scenarios
    max_vol_c: cover property (
        conv.valid && conv.volume == VOL_MAX);
    min_vol_c: cover property (
        conv.valid && conv.volume == VOL_MIN);
    play_c: cover property (
        wr_ctrl && bus.wdata[EN_BIT] ##1 wr_high ##1 wr_low);
    stop_c: cover property (
        conv.valid ##1 !conv.valid);
    ctrl_rd_c: cover property (
        rd_ctrl ##1 rdata[EN_BIT]);
endmodule

// [test/vdc_speaker.sv]
`timescale 1ns/1ps
module vdc_speaker (
    input  wire vdc_pkg::vdc_out_t conv,
    input  wire logic              pin_sel_conv,
    output logic [11:0]            heard
);
    import vdc_pkg::*;
    // Speaker hears only a valid feed routed to the pin
    assign heard = (pin_sel_conv && conv.valid) ? conv.sample : 12'h000;
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import vdc_pkg::*;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b0;
    vdc_bus_t   bus = '0;
    logic       alt_out = 1'b0;
    logic       alt_oe_n = 1'b1;
    logic [7:0] rdata;
    vdc_out_t   conv;
    logic       sel, pout, poe_n;
    logic [11:0] heard;
    logic [7:0] lo = 8'h00, hi = 8'h00, ct = 8'h00, v;
    int         n_fail = 0, comparisons = 0;
    always #10 clk_sys = ~clk_sys;
    vdc_top u_vdc_top (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
        .rdata(rdata), .pin_alt_out(alt_out), .pin_alt_oe_n(alt_oe_n),
        .conv(conv), .pin_sel_conv(sel), .pin_out(pout), .pin_oe_n(poe_n));
    vdc_speaker u_vdc_speaker (.conv(conv), .pin_sel_conv(sel),
        .heard(heard));
    function automatic logic [7:0] exp_rd(input logic [1:0] a);
        case (a)
            ADDR_LOW:  return {lo[7:4], 4'h0};
            ADDR_HIGH: return hi;
            ADDR_CTRL: return {ct[7:5], 4'h0, ct[0]};
            default:   return 8'h00;
        endcase
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        bus <= '0;
        if (a == ADDR_LOW) lo = d;
        else if (a == ADDR_HIGH) hi = d;
        else if (a == ADDR_CTRL) ct = d;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [1:0] a);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        bus <= '0;
        #1 chk(rdata, exp_rd(a));
        @(posedge clk_sys);
    endtask
    task automatic chk_pin();
        #1;
        chk(conv, ct[0] ? {1'b1, ct[7:5], hi, lo[7:4]} : 16'h0000);
        chk({sel, pout, poe_n},
            ct[0] ? 3'b101 : {1'b0, alt_out, alt_oe_n});
        chk(heard, ct[0] ? {hi, lo[7:4]} : 12'h000);
        @(posedge clk_sys);
    endtask
    task automatic end_sim();
        $display("TB: %0d mismatches, %0d comparisons", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h006d9d0f));
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        for (int a = 0; a < 4; a++) rd(2'(a));
        chk_pin();
        wr(ADDR_HIGH, 8'hA5);
        wr(ADDR_LOW, 8'hFF);
        for (int k = 0; k < 8; k++) begin
            wr(ADDR_CTRL, {3'(k), 5'h1F});
            chk_pin();
            rd(ADDR_CTRL);
        end
        wr(ADDR_CTRL, 8'hE0);
        chk_pin();
        for (int i = 0; i < 60; i++) begin
            v = 8'($urandom);
            alt_out <= v[2];
            alt_oe_n <= v[3];
            wr(v[1:0], 8'($urandom));
            chk_pin();
            rd(v[1:0]);
        end
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        lo = 8'h00;
        hi = 8'h00;
        ct = 8'h00;
        @(posedge clk_sys);
        chk_pin();
        for (int a = 0; a < 4; a++) rd(2'(a));
        end_sim();
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        n_fail++;
        end_sim();
    end
endmodule
